// ===== logic/interp_drive_end.sv
// Drive end: objects, SYNC commit, overtime alarm, torque clamp, remote inputs
`timescale 1ns/1ns
`default_nettype none
// Rules for this block and for the host end
// (RL1) Only the latest committed setpoint is used
// (RL2) Host sends setpoint and control before SYNC
// (RL3) SYNC realigns the interpolation cycle timing
// (RL4) Host SYNC period not above interpolation period
// (RL5) Received process data applied only at SYNC
// (RL6) Late data keeps previously committed setpoint
// (RL7) Period without update raises alarm, stops axis
// (RL8) Host maps control word, setpoint; starts last
// (RL9) Host programs period before enabling mode
// (RL10) Host sets receive transmission type to one
// (RL11) Host writes mode seven before start
// (RL12) Output torque clamped between both limits while bus_control_active is high
// (RL13) Positive limit 16-bit, 0 to 3000, reset 3000
// (RL14) Negative limit 16-bit, 0 to 3000, reset 3000
// (RL15) Output word bits 28-30 are remote inputs
// (RL16) Remote function, inversion from drive configuration
// (RL17) Read-only input word: limits, home, connector
// (RL18) Control bit 4 enables, bit 8 halts
// (RL19) Status bit 12 active, bit 10 reached/still
// (RL20) Only setpoint subindex 1 is used
// (RL21) Mask selects which output bits take effect
// (RL22) Overtime counter reloaded at a SYNC that commits a new setpoint
module interp_drive_end #(
  parameter int TICK_CYCLES = sync_interp_pkg::PERIOD_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  fieldbus_if.device bus,
  input wire logic [7:0] connector_pins,
  input wire logic neg_limit_pin,
  input wire logic pos_limit_pin,
  input wire logic home_pin,
  input wire logic motor_still_pin,
  input wire logic bus_control_active,
  input wire logic [5:0] remote_func_sel,
  input wire logic [2:0] remote_invert,
  input wire logic signed [15:0] torque_request,
  input wire logic [31:0] position_feedback,
  output logic signed [15:0] torque_cmd,
  output logic [31:0] position_target,
  output logic interp_active_flag,
  output logic axis_stop,
  output logic overtime_alarm,
  output logic neg_limit_active,
  output logic pos_limit_active,
  output logic home_active
);
  import sync_interp_pkg::*;

  function automatic logic remote_hit(input logic [2:0] lvl, input logic [5:0] sel,
                                      input remote_func_t f);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < REMOTE_COUNT; i++) begin
      hit = hit | (lvl[i] && (sel[2*i +: 2] == f));
    end
    return hit;
  endfunction : remote_hit

  logic [11:0] pin_meta_q;
  logic [11:0] pin_q;
  logic started_q;
  logic [15:0] pend_cw_q;
  logic [31:0] pend_pos_q;
  logic pend_new_q;
  logic [15:0] cw_q;
  logic [31:0] target_q;
  logic [7:0] mode_q;
  logic [7:0] period_q;
  logic [15:0] pos_lim_q;
  logic [15:0] neg_lim_q;
  logic [31:0] out_word_q;
  logic [31:0] out_mask_q;
  logic [31:0] out_eff_q;
  logic [2:0] remote_lvl;
  logic commit;
  logic run;
  logic expired;
  logic [31:0] din_word;
  logic [15:0] status_word;
  logic wr_ok;
  logic signed [16:0] req_x;
  logic signed [16:0] hi_x;
  logic signed [16:0] lo_x;

  // Two-stage synchronisers for pins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= '0;
      pin_q <= '0;
    end else begin
      pin_meta_q <= {motor_still_pin, home_pin, pos_limit_pin, neg_limit_pin, connector_pins};
      pin_q <= pin_meta_q;
    end
  end

  assign commit = bus.sync_pulse && started_q; // [RL5]
  assign wr_ok = bus.obj_wr;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      started_q <= 1'b0;
    end else if (bus.nmt_start) begin
      started_q <= 1'b1;
    end
  end

  // Staged process data; a write in the SYNC cycle stays pending
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pend_cw_q <= '0;
      pend_pos_q <= '0;
      pend_new_q <= 1'b0;
    end else begin
      if (commit) begin
        pend_new_q <= 1'b0;
      end
      if (wr_ok && bus.obj_index == OBJ_CONTROL && bus.obj_sub == SUB_0) begin
        pend_cw_q <= bus.obj_wdata[15:0];
      end
      if (wr_ok && bus.obj_index == OBJ_INTERP_DATA && bus.obj_sub == SUB_1) begin // [RL20]
        pend_pos_q <= bus.obj_wdata;
        pend_new_q <= 1'b1;
      end
    end
  end

  // Working values change only at SYNC; no queue of setpoints
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cw_q <= '0;
      target_q <= '0;
    end else if (commit) begin
      cw_q <= pend_cw_q; // [RL5]
      target_q <= pend_pos_q; // [RL1] [RL6]
    end
  end

  // Configuration objects; out-of-range torque limits are refused
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q <= '0;
      period_q <= PERIOD_RESET;
      pos_lim_q <= TORQUE_LIMIT_RESET; // [RL13]
      neg_lim_q <= TORQUE_LIMIT_RESET; // [RL14]
      out_word_q <= '0;
      out_mask_q <= '0;
    end else if (wr_ok) begin
      unique case (bus.obj_index)
        OBJ_OP_MODE: mode_q <= bus.obj_wdata[7:0];
        OBJ_INTERP_PERIOD: if (bus.obj_sub == SUB_1) period_q <= bus.obj_wdata[7:0];
        OBJ_POS_TORQUE: if (bus.obj_wdata <= 32'(TORQUE_LIMIT_MAX)) begin
          pos_lim_q <= bus.obj_wdata[15:0]; // [RL13]
        end
        OBJ_NEG_TORQUE: if (bus.obj_wdata <= 32'(TORQUE_LIMIT_MAX)) begin
          neg_lim_q <= bus.obj_wdata[15:0]; // [RL14]
        end
        OBJ_DIG_OUTPUTS: begin
          if (bus.obj_sub == SUB_1) out_word_q <= bus.obj_wdata;
          if (bus.obj_sub == SUB_2) out_mask_q <= bus.obj_wdata;
        end
        default: ;
      endcase
    end
  end

  // Only masked-in bits of the output word take effect
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_eff_q <= '0;
    end else begin
      out_eff_q <= (out_eff_q & ~out_mask_q) | (out_word_q & out_mask_q); // [RL21]
    end
  end

  assign remote_lvl = out_eff_q[REMOTE_LSB +: REMOTE_COUNT] ^ remote_invert; // [RL15] [RL16]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      neg_limit_active <= 1'b0;
      pos_limit_active <= 1'b0;
      home_active <= 1'b0;
    end else begin
      neg_limit_active <= pin_q[8] | remote_hit(remote_lvl, remote_func_sel, FUNC_NEG_LIMIT);
      pos_limit_active <= pin_q[9] | remote_hit(remote_lvl, remote_func_sel, FUNC_POS_LIMIT);
      home_active <= pin_q[10] | remote_hit(remote_lvl, remote_func_sel, FUNC_HOME); // [RL15]
    end
  end

  // Mode control and overtime alarm
  assign run = started_q && mode_q == MODE_INTERP && cw_q[CW_INTERP_ENABLE]; // [RL18]

  interp_watchdog #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_watchdog (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .realign(bus.sync_pulse), // [RL3]
    .reload((commit && pend_new_q) || !interp_active_flag), // [RL22]
    .arm(interp_active_flag),
    .period(period_q),
    .expired(expired)
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      overtime_alarm <= 1'b0;
    end else if (expired) begin
      overtime_alarm <= 1'b1; // [RL7]
    end else if (!run) begin
      overtime_alarm <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      interp_active_flag <= 1'b0;
      axis_stop <= 1'b1;
      position_target <= '0;
    end else begin
      interp_active_flag <= run && !cw_q[CW_HALT] && !overtime_alarm && !expired; // [RL18]
      axis_stop <= !run || cw_q[CW_HALT] || overtime_alarm || expired; // [RL7] [RL18]
      if (interp_active_flag) begin
        position_target <= target_q; // [RL6]
      end
    end
  end

  // Torque clamp
  assign req_x = 17'(torque_request);
  assign hi_x = $signed({1'b0, pos_lim_q});
  assign lo_x = -$signed({1'b0, neg_lim_q});

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      torque_cmd <= '0;
    end else if (bus_control_active && req_x > hi_x) begin
      torque_cmd <= hi_x[15:0]; // [RL12]
    end else if (bus_control_active && req_x < lo_x) begin
      torque_cmd <= lo_x[15:0]; // [RL12]
    end else begin
      torque_cmd <= torque_request;
    end
  end

  // Read-back words
  always_comb begin
    din_word = '0;
    din_word[DI_NEG_LIMIT] = neg_limit_active;
    din_word[DI_POS_LIMIT] = pos_limit_active;
    din_word[DI_HOME] = home_active;
    din_word[DI_CONN_LSB +: CONN_COUNT] = pin_q[7:0]; // [RL17]
  end

  always_comb begin
    status_word = '0;
    status_word[SW_INTERP_ACTIVE] = interp_active_flag; // [RL19]
    status_word[SW_TARGET_REACHED] = cw_q[CW_HALT] ? pin_q[11]
                                   : (position_feedback == target_q); // [RL19]
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bus.obj_rdata <= '0;
    end else if (!bus.obj_rd) begin
      bus.obj_rdata <= '0;
    end else begin
      unique case (bus.obj_index)
        OBJ_CONTROL: bus.obj_rdata <= {16'h0000, cw_q};
        OBJ_STATUS: bus.obj_rdata <= {16'h0000, status_word};
        OBJ_OP_MODE: bus.obj_rdata <= {24'h000000, mode_q};
        OBJ_INTERP_DATA: bus.obj_rdata <= target_q;
        OBJ_INTERP_PERIOD: bus.obj_rdata <= {24'h000000, period_q};
        OBJ_POS_TORQUE: bus.obj_rdata <= {16'h0000, pos_lim_q};
        OBJ_NEG_TORQUE: bus.obj_rdata <= {16'h0000, neg_lim_q};
        OBJ_DIG_INPUTS: bus.obj_rdata <= din_word; // [RL17]
        OBJ_DIG_OUTPUTS: bus.obj_rdata <= (bus.obj_sub == SUB_2) ? out_mask_q : out_word_q;
        default: bus.obj_rdata <= '0;
      endcase
    end
  end
endmodule : interp_drive_end
`default_nettype wire

// ===== logic/sync_interp_pkg.sv
// Shared object indices, field positions and timing for the interpolation link
package sync_interp_pkg;
  localparam logic [15:0] OBJ_CONTROL = 16'h6040;
  localparam logic [15:0] OBJ_STATUS = 16'h6041;
  localparam logic [15:0] OBJ_OP_MODE = 16'h6060;
  localparam logic [15:0] OBJ_INTERP_DATA = 16'h60c1;
  localparam logic [15:0] OBJ_INTERP_PERIOD = 16'h60c2;
  localparam logic [15:0] OBJ_POS_TORQUE = 16'h60e0;
  localparam logic [15:0] OBJ_NEG_TORQUE = 16'h60e1;
  localparam logic [15:0] OBJ_DIG_INPUTS = 16'h60fd;
  localparam logic [15:0] OBJ_DIG_OUTPUTS = 16'h60fe;
  localparam logic [15:0] OBJ_RX_COMM_1 = 16'h1400;
  localparam logic [15:0] OBJ_RX_COMM_2 = 16'h1401;
  localparam logic [15:0] OBJ_RX_MAP_1 = 16'h1600;
  localparam logic [15:0] OBJ_RX_MAP_2 = 16'h1601;
  localparam logic [7:0] SUB_0 = 8'h00;
  localparam logic [7:0] SUB_1 = 8'h01;
  localparam logic [7:0] SUB_2 = 8'h02;
  localparam logic [31:0] MAP_CONTROL = 32'h6040_0010;
  localparam logic [31:0] MAP_SETPOINT = 32'h60c1_0120;
  localparam logic [31:0] TRANS_SYNC = 32'h0000_0001;
  localparam logic [7:0] MODE_INTERP = 8'h07;
  localparam logic [7:0] PERIOD_RESET = 8'h01;
  localparam logic [15:0] TORQUE_LIMIT_MAX = 16'hbb8;
  localparam logic [15:0] TORQUE_LIMIT_RESET = 16'hbb8;
  localparam int CW_INTERP_ENABLE = 4;
  localparam int CW_HALT = 8;
  localparam int SW_TARGET_REACHED = 10;
  localparam int SW_INTERP_ACTIVE = 12;
  localparam int DI_NEG_LIMIT = 0;
  localparam int DI_POS_LIMIT = 1;
  localparam int DI_HOME = 2;
  localparam int DI_CONN_LSB = 16;
  localparam int REMOTE_LSB = 28;
  localparam int REMOTE_COUNT = 3;
  localparam int CONN_COUNT = 8;
  typedef enum logic [1:0] {
    FUNC_NONE = 2'h0,
    FUNC_NEG_LIMIT = 2'h1,
    FUNC_POS_LIMIT = 2'h2,
    FUNC_HOME = 2'h3
  } remote_func_t;
  // Period unit is one millisecond
  localparam int CLK_PERIOD_NS = 50;
  localparam int PERIOD_UNIT_NS = 1000000;
  localparam int PERIOD_UNIT_CYCLES = PERIOD_UNIT_NS / CLK_PERIOD_NS;
  // Controller register map
  localparam logic [2:0] HREG_OBJECT = 3'h0;
  localparam logic [2:0] HREG_DATA = 3'h1;
  localparam logic [2:0] HREG_COMMAND = 3'h2;
  localparam logic [2:0] HREG_READ_DATA = 3'h3;
  localparam logic [2:0] HREG_SETPOINT = 3'h4;
  localparam logic [2:0] HREG_CONTROL = 3'h5;
  localparam logic [2:0] HREG_PERIOD = 3'h6;
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ = 1;
  localparam int CMD_CYCLE = 2;
  localparam int CMD_CONFIG = 3;
  localparam logic [2:0] CFG_STEPS = 3'h6;
endpackage : sync_interp_pkg

// ===== logic/fieldbus_if.sv
// Object access, SYNC and start signalling between controller and drive
`timescale 1ns/1ns
`default_nettype none
interface fieldbus_if (
  input wire logic clk_sys
);
  logic obj_wr;
  logic obj_rd;
  logic [15:0] obj_index;
  logic [7:0] obj_sub;
  logic [31:0] obj_wdata;
  logic [31:0] obj_rdata;
  logic sync_pulse;
  logic nmt_start;
  modport device (input clk_sys, input obj_wr, input obj_rd, input obj_index, input obj_sub,
    input obj_wdata, output obj_rdata, input sync_pulse, input nmt_start);
  modport host (input clk_sys, output obj_wr, output obj_rd, output obj_index,
    output obj_sub, output obj_wdata, input obj_rdata, output sync_pulse, output nmt_start);
endinterface : fieldbus_if
`default_nettype wire

// ===== logic/interp_watchdog.sv
// Interpolation period timer, realigned at SYNC and reloaded on fresh data
`timescale 1ns/1ns
`default_nettype none
module interp_watchdog #(
  parameter int TICK_CYCLES = sync_interp_pkg::PERIOD_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic realign,
  input wire logic reload,
  input wire logic arm,
  input wire logic [7:0] period,
  output logic expired
);
  import sync_interp_pkg::*;
  localparam int DW = $clog2(TICK_CYCLES + 1);
  localparam logic [DW-1:0] TICK_LAST = DW'(TICK_CYCLES - 1);
  logic [DW-1:0] div_q;
  logic [7:0] left_q;
  logic tick;

  assign tick = (div_q == TICK_LAST) && !realign;

  // Unit divider restarts on every SYNC
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
    end else if (realign || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      left_q <= PERIOD_RESET;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (reload) begin
        left_q <= period;
      end else if (arm && tick) begin
        if (left_q <= 8'h01) begin
          expired <= 1'b1;
          left_q <= period;
        end else begin
          left_q <= left_q - 8'h01;
        end
      end
    end
  end
endmodule : interp_watchdog
`default_nettype wire

// ===== logic/interp_host_end.sv
// Controller end: register port to object writes, reads, cycles and start-up
`timescale 1ns/1ns
`default_nettype none
module interp_host_end (
  input wire logic clk_sys,
  input wire logic resetn,
  fieldbus_if.host bus,
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import sync_interp_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_CONFIG = 7'b0000010,
    ST_SEND_CW = 7'b0000100,
    ST_SEND_POS = 7'b0001000,
    ST_SEND_SYNC = 7'b0010000,
    ST_READ_WAIT = 7'b0100000,
    ST_READ_TAKE = 7'b1000000
  } state_t;

  // Start-up order: mapping, period, sync transmission, mode; start follows
  function automatic logic [55:0] cfg_entry(input logic [2:0] step, input logic [7:0] per);
    logic [55:0] e;
    e = '0;
    unique case (step)
      3'h0: e = {OBJ_RX_MAP_1, SUB_1, MAP_CONTROL};
      3'h1: e = {OBJ_RX_MAP_2, SUB_1, MAP_SETPOINT};
      3'h2: e = {OBJ_INTERP_PERIOD, SUB_1, 24'h000000, per};
      3'h3: e = {OBJ_RX_COMM_1, SUB_2, TRANS_SYNC};
      3'h4: e = {OBJ_RX_COMM_2, SUB_2, TRANS_SYNC};
      default: e = {OBJ_OP_MODE, SUB_0, 24'h000000, MODE_INTERP};
    endcase
    return e;
  endfunction : cfg_entry

  state_t state_q;
  logic [2:0] step_q;
  logic [23:0] obj_sel_q;
  logic [31:0] data_q;
  logic [31:0] rd_data_q;
  logic [31:0] setpoint_q;
  logic [15:0] control_q;
  logic [7:0] period_q;
  logic wr_q;
  logic rd_q;
  logic sync_q;
  logic start_q;
  logic [15:0] idx_q;
  logic [7:0] sub_q;
  logic [31:0] wdata_q;
  logic cmd;

  assign bus.obj_wr = wr_q;
  assign bus.obj_rd = rd_q;
  assign bus.obj_index = idx_q;
  assign bus.obj_sub = sub_q;
  assign bus.obj_wdata = wdata_q;
  assign bus.sync_pulse = sync_q;
  assign bus.nmt_start = start_q;
  assign cmd = reg_wr && reg_addr == HREG_COMMAND && state_q == ST_IDLE;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      obj_sel_q <= '0;
      data_q <= '0;
      setpoint_q <= '0;
      control_q <= '0;
      period_q <= PERIOD_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        HREG_OBJECT: obj_sel_q <= reg_wdata[23:0];
        HREG_DATA: data_q <= reg_wdata;
        HREG_SETPOINT: setpoint_q <= reg_wdata;
        HREG_CONTROL: control_q <= reg_wdata[15:0];
        HREG_PERIOD: period_q <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      step_q <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      sync_q <= 1'b0;
      start_q <= 1'b0;
      idx_q <= '0;
      sub_q <= '0;
      wdata_q <= '0;
      rd_data_q <= '0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      sync_q <= 1'b0;
      start_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (cmd && reg_wdata[CMD_WRITE]) begin
            {idx_q, sub_q, wdata_q} <= {obj_sel_q, data_q};
            wr_q <= 1'b1;
          end else if (cmd && reg_wdata[CMD_READ]) begin
            {idx_q, sub_q} <= obj_sel_q;
            rd_q <= 1'b1;
            state_q <= ST_READ_WAIT;
          end else if (cmd && reg_wdata[CMD_CYCLE]) begin
            state_q <= ST_SEND_CW;
          end else if (cmd && reg_wdata[CMD_CONFIG]) begin
            step_q <= '0;
            state_q <= ST_CONFIG;
          end
        end
        ST_CONFIG: begin
          if (step_q == CFG_STEPS) begin
            start_q <= 1'b1; // [RL8] [RL11]
            state_q <= ST_IDLE;
          end else begin
            {idx_q, sub_q, wdata_q} <= cfg_entry(step_q, period_q); // [RL8] [RL9] [RL10]
            wr_q <= 1'b1;
            step_q <= step_q + 3'h1;
          end
        end
        ST_SEND_CW: begin
          {idx_q, sub_q, wdata_q} <= {OBJ_CONTROL, SUB_0, 16'h0000, control_q}; // [RL2]
          wr_q <= 1'b1;
          state_q <= ST_SEND_POS;
        end
        ST_SEND_POS: begin
          {idx_q, sub_q, wdata_q} <= {OBJ_INTERP_DATA, SUB_1, setpoint_q}; // [RL2]
          wr_q <= 1'b1;
          state_q <= ST_SEND_SYNC;
        end
        ST_SEND_SYNC: begin
          sync_q <= 1'b1; // [RL2]
          state_q <= ST_IDLE;
        end
        ST_READ_WAIT: state_q <= ST_READ_TAKE;
        ST_READ_TAKE: begin
          rd_data_q <= bus.obj_rdata;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        HREG_OBJECT: reg_rdata <= {8'h00, obj_sel_q};
        HREG_DATA: reg_rdata <= data_q;
        HREG_COMMAND: reg_rdata <= {31'h0, state_q != ST_IDLE};
        HREG_READ_DATA: reg_rdata <= rd_data_q;
        HREG_SETPOINT: reg_rdata <= setpoint_q;
        HREG_CONTROL: reg_rdata <= {16'h0000, control_q};
        HREG_PERIOD: reg_rdata <= {24'h000000, period_q};
        default: reg_rdata <= '0;
      endcase
    end
  end
endmodule : interp_host_end
`default_nettype wire

// ===== verif/link_properties.sv
// Protocol checks on the link between controller and drive
`timescale 1ns/1ns
`default_nettype none
module link_properties
  import sync_interp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic obj_wr,
  input wire logic obj_rd,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_sub,
  input wire logic [31:0] obj_wdata,
  input wire logic [31:0] obj_rdata,
  input wire logic sync_pulse,
  input wire logic nmt_start
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_wr(i);
    obj_wr && obj_index == i;
  endsequence
  sequence s_cfg;
    s_wr(OBJ_RX_MAP_1) ##1 s_wr(OBJ_RX_MAP_2) ##1 s_wr(OBJ_INTERP_PERIOD) ##1
      s_wr(OBJ_RX_COMM_1) ##1 s_wr(OBJ_RX_COMM_2) ##1 s_wr(OBJ_OP_MODE);
  endsequence
  sequence s_cyc;
    s_wr(OBJ_CONTROL) ##1 s_wr(OBJ_INTERP_DATA) ##0 obj_sub == SUB_1;
  endsequence
  property p_start_after_cfg;
    s_cfg |=> nmt_start;
  endproperty
  a_start_after_cfg: assert property (p_start_after_cfg)
    else $error("start missing after configuration");
  property p_start_mode;
    nmt_start |-> $past(obj_wr) && $past(obj_index) == OBJ_OP_MODE
      && $past(obj_wdata) == {24'h0, MODE_INTERP};
  endproperty
  a_start_mode: assert property (p_start_mode)
    else $error("start not preceded by mode write");
  property p_sync_after_data;
    s_cyc |=> sync_pulse;
  endproperty
  a_sync_after_data: assert property (p_sync_after_data)
    else $error("sync missing after control and setpoint");
  property p_sync_has_data;
    sync_pulse |-> $past(obj_wr) && $past(obj_index) == OBJ_INTERP_DATA;
  endproperty
  a_sync_has_data: assert property (p_sync_has_data)
    else $error("sync without setpoint before it");
  property p_trans_type;
    obj_wr && (obj_index == OBJ_RX_COMM_1 || obj_index == OBJ_RX_COMM_2)
      |-> obj_sub == SUB_2 && obj_wdata == TRANS_SYNC;
  endproperty
  a_trans_type: assert property (p_trans_type)
    else $error("receive transmission type not synchronous");
  property p_map;
    s_wr(OBJ_RX_MAP_2) |-> obj_wdata == MAP_SETPOINT && obj_sub == SUB_1;
  endproperty
  a_map: assert property (p_map)
    else $error("setpoint mapping wrong");
  property p_di_reserved;
    $past(obj_rd) && $past(obj_index) == OBJ_DIG_INPUTS
      |-> obj_rdata[15:3] == 13'h0 && obj_rdata[31:24] == 8'h0;
  endproperty
  a_di_reserved: assert property (p_di_reserved)
    else $error("reserved input bits not zero");
  property p_torque_range;
    $past(obj_rd) && $past(obj_index) == OBJ_POS_TORQUE
      |-> obj_rdata <= {16'h0, TORQUE_LIMIT_MAX};
  endproperty
  a_torque_range: assert property (p_torque_range)
    else $error("torque limit above range");
endmodule : link_properties
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for both link ends
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sync_interp_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] ra = 3'h0;
  logic [31:0] rw = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rq;
  logic [7:0] cp = 8'h0;
  logic nl = 1'b0, pl = 1'b0, hp = 1'b0, ms = 1'b0, bca = 1'b1;
  logic [5:0] fs = 6'h0;
  logic [2:0] inv = 3'h0;
  logic signed [15:0] tr = 16'sh0;
  logic signed [15:0] tc;
  logic [31:0] fb = 32'h0;
  logic [31:0] pt;
  logic ia, st, al, na, pa, ha;
  int fail_count = 0;
  int checked = 0;
  int seed = 32'h4561;
  always #25 clk_sys = ~clk_sys;
  fieldbus_if fieldbus_if_inst (.clk_sys(clk_sys));
  interp_host_end interp_host_end_inst (.clk_sys(clk_sys), .resetn(resetn),
    .bus(fieldbus_if_inst.host), .reg_addr(ra), .reg_wdata(rw), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rq));
  interp_drive_end #(.TICK_CYCLES(10)) interp_drive_end_inst (.clk_sys(clk_sys),
    .resetn(resetn), .bus(fieldbus_if_inst.device), .connector_pins(cp),
    .neg_limit_pin(nl), .pos_limit_pin(pl), .home_pin(hp), .motor_still_pin(ms),
    .bus_control_active(bca), .remote_func_sel(fs), .remote_invert(inv),
    .torque_request(tr), .position_feedback(fb), .torque_cmd(tc),
    .position_target(pt), .interp_active_flag(ia), .axis_stop(st),
    .overtime_alarm(al), .neg_limit_active(na), .pos_limit_active(pa),
    .home_active(ha));
  link_properties link_properties_inst (.clk_sys(clk_sys), .resetn(resetn),
    .obj_wr(fieldbus_if_inst.obj_wr), .obj_rd(fieldbus_if_inst.obj_rd),
    .obj_index(fieldbus_if_inst.obj_index), .obj_sub(fieldbus_if_inst.obj_sub),
    .obj_wdata(fieldbus_if_inst.obj_wdata), .obj_rdata(fieldbus_if_inst.obj_rdata),
    .sync_pulse(fieldbus_if_inst.sync_pulse), .nmt_start(fieldbus_if_inst.nmt_start));
  task automatic results();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rwr(logic [2:0] a, logic [31:0] d);
    @(posedge clk_sys);
    ra <= a;
    rw <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : rwr
  task automatic rrd(logic [2:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    d = rq;
    @(posedge clk_sys);
  endtask : rrd
  task automatic cmd(logic [31:0] c);
    logic [31:0] s;
    rwr(HREG_COMMAND, c);
    for (int i = 0; i < 40; i++) begin
      rrd(HREG_COMMAND, s);
      if (s[0] === 1'b0) return;
    end
    fail_count++;
    results();
  endtask : cmd
  task automatic ow(logic [15:0] i, logic [7:0] s, logic [31:0] d);
    rwr(HREG_OBJECT, {8'h0, i, s});
    rwr(HREG_DATA, d);
    cmd(32'h1);
  endtask : ow
  task automatic orr(logic [15:0] i, logic [7:0] s, output logic [31:0] d);
    rwr(HREG_OBJECT, {8'h0, i, s});
    cmd(32'h2);
    rrd(HREG_READ_DATA, d);
  endtask : orr
  task automatic cyc(logic [31:0] c, logic [31:0] p);
    rwr(HREG_CONTROL, c);
    rwr(HREG_SETPOINT, p);
    cmd(32'h4);
    repeat (3) @(posedge clk_sys);
  endtask : cyc
  function automatic logic signed [15:0] clamp(logic signed [15:0] r, logic [15:0] p, n);
    if (r > $signed(p)) return $signed(p);
    if (r < -$signed(n)) return -$signed(n);
    return r;
  endfunction : clamp
  initial begin
    logic [31:0] d, p, n, x;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    orr(OBJ_POS_TORQUE, SUB_0, d);
    chk("pos_limit", 32'hbb8, d);
    orr(OBJ_NEG_TORQUE, SUB_0, d);
    chk("neg_limit", 32'hbb8, d);
    p = $unsigned($random(seed)) % 3001;
    n = $unsigned($random(seed)) % 3001;
    ow(OBJ_POS_TORQUE, SUB_0, p);
    ow(OBJ_NEG_TORQUE, SUB_0, n);
    ow(OBJ_POS_TORQUE, SUB_0, 32'd3001);
    orr(OBJ_POS_TORQUE, SUB_0, d);
    chk("pos_limit", p, d);
    for (int i = 0; i < 12; i++) begin
      tr <= (i == 0) ? 16'sh7fff : (i == 1) ? 16'sh8000 : 16'($random(seed));
      bca <= i != 1;
      repeat (3) @(posedge clk_sys);
      chk("torque_cmd", bca ? clamp(tr, p[15:0], n[15:0]) : tr, tc);
    end
    $display("test torque done");
    cp <= 8'($random(seed));
    {hp, pl, nl} <= 3'b101;
    repeat (4) @(posedge clk_sys);
    orr(OBJ_DIG_INPUTS, SUB_0, d);
    chk("dig_inputs", {8'h0, cp, 13'h0, 3'b101}, d);
    {hp, pl, nl} <= 3'b000;
    fs <= 6'h27;
    ow(OBJ_DIG_OUTPUTS, SUB_2, 32'h7000_0000);
    ow(OBJ_DIG_OUTPUTS, SUB_1, 32'h5000_0000);
    repeat (4) @(posedge clk_sys);
    chk("remote", 3'b101, {ha, na, pa});
    ow(OBJ_DIG_OUTPUTS, SUB_2, 32'h0);
    ow(OBJ_DIG_OUTPUTS, SUB_1, 32'h2000_0000);
    repeat (4) @(posedge clk_sys);
    chk("remote", 3'b101, {ha, na, pa});
    inv <= 3'b111;
    repeat (4) @(posedge clk_sys);
    chk("remote", 3'b010, {ha, na, pa});
    inv <= 3'b000;
    ow(OBJ_DIG_OUTPUTS, SUB_2, 32'h7000_0000);
    ow(OBJ_DIG_OUTPUTS, SUB_1, 32'h0);
    $display("test inputs done");
    rwr(HREG_PERIOD, 32'h10);
    cmd(32'h8);
    x = $random(seed);
    cyc(32'h10, x);
    chk("target", x, pt);
    chk("active", 1, ia);
    fb <= x;
    orr(OBJ_STATUS, SUB_0, d);
    chk("status", 2'b11, {d[12], d[10]});
    cyc(32'h110, x + 2);
    chk("active", 0, ia);
    ms <= 1'b1;
    orr(OBJ_STATUS, SUB_0, d);
    chk("status", 2'b01, {d[12], d[10]});
    for (int i = 0; i < 6; i++) begin
      x = $random(seed);
      cyc(32'h10, x);
      chk("target", x, pt);
    end
    ow(OBJ_INTERP_DATA, SUB_2, ~x);
    ow(OBJ_INTERP_DATA, SUB_1, x + 1);
    chk("target", x, pt);
    repeat (80) @(posedge clk_sys);
    chk("alarm", 0, al);
    chk("target", x, pt);
    for (int i = 0; i < 300 && al !== 1'b1; i++) @(posedge clk_sys);
    chk("alarm", 1, al);
    chk("stop", 1, st);
    cyc(32'h0, x);
    chk("alarm", 0, al);
    cyc(32'h10, x + 5);
    chk("target", x + 5, pt);
    $display("test interpolation done");
    results();
  end
endmodule : testbench
`default_nettype wire
